// ===== verilog/scd_decoder.sv
// The plain strobed port and the address map were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "scd_map.svh"
module scd_decoder (
  input wire logic mclk,
  input wire logic reset_n,
  // register port
  input wire logic [`SCD_ADDR_W-1:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [15:0] rdata,
  // device side inputs
  input wire logic start_in,
  input wire logic move_busy,
  input wire logic model_sel,
  input wire logic [15:0] cfg_current,
  // move launch
  output logic move_go,
  output scd_pkg::scd_move_t move_kind,
  output logic move_ccw,
  output logic enc_reg_move,
  output logic [31:0] target_pos,
  output logic [31:0] speed,
  output logic [15:0] accel,
  output logic [15:0] decel,
  output logic [15:0] jerk,
  output logic [15:0] dwell_ms,
  output logic [31:0] reg_min_dist,
  // other commands
  output logic hold_go,
  output logic resume_go,
  output logic istop_go,
  output logic save_go,
  output logic pos_invalid,
  output logic gear_mode,
  output logic hybrid_mode,
  output logic [15:0] motor_current,
  output logic cmd_error
);
  import scd_pkg::*;
  ////////////////////////////////////////////////////////////////////////
  // declarations
  logic [15:0] cw_r [0:`SCD_NWORDS-1]; // command words from the master
  logic upd; // network update strobe
  logic [15:0] rise; // word 0 rising bits
  logic [15:0] fall; // word 0 falling bits
  logic evt_vld; // edges valid this cycle
  logic [15:0] w0; // command word 0
  logic [15:0] w1; // motion option word
  logic cur_ok; // keyed current is valid
  logic [15:0] cur_new; // current to apply
  scd_state_t state_r; // decoder state
  scd_state_t state_nxt;
  scd_move_t kind_r; // pending or launched move
  logic start_prev_r; // start input last cycle
  logic start_rise; // start input edge
  logic [2:0] keys; // key2 key1 key0
  logic key_match; // key pattern armed
  logic key_block; // command excludes keyed current
  logic is_move; // a move bit rose
  logic params_ok; // data words within range
  logic pos_ok; // target fits 24 signed bits
  logic fire_now; // launch without waiting
  logic fire_idx; // launch from index input
  logic [15:0] rd_nxt; // read data next
  scd_move_t kind_nxt; // decoded kind
  ////////////////////////////////////////////////////////////////////////
  // register writes; commit index marks a network update
  assign upd = wr_en && (addr == `SCD_REG_COMMIT);
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < `SCD_NWORDS; i++) begin
        cw_r[i] <= 16'h0000;
      end
    end else if (wr_en && (addr < `SCD_REG_COMMIT)) begin
      cw_r[addr[3:0]] <= wdata; // data words by index
    end
  end
  assign w0 = cw_r[0];
  assign w1 = cw_r[1];
  assign keys = {w1[`SCD_W1_SAVE], w1[`SCD_W1_KEY1], w1[`SCD_W1_KEY0]};
  ////////////////////////////////////////////////////////////////////////
  // edge finder on command word 0
  scd_edge_detect u_edge (
    .mclk(mclk),
    .reset_n(reset_n),
    .upd(upd),
    .word(w0),
    .rise(rise),
    .fall(fall),
    .vld(evt_vld)
  );
  // keyed current check
  scd_current_check u_cur (
    .req(cw_r[8]),
    .model_sel(model_sel),
    .cfg_current(cfg_current),
    .ok(cur_ok),
    .applied(cur_new)
  );
  ////////////////////////////////////////////////////////////////////////
  // command decode
  always_comb begin
    is_move = rise[`SCD_W0_ABS] | rise[`SCD_W0_REL] | rise[`SCD_W0_JOG_CW] |
              rise[`SCD_W0_JOG_CCW] | rise[`SCD_W0_RUN_ASM];
    // target must be sign extension of bit 23
    pos_ok = (cw_r[2][15:7] == 9'h000) || (cw_r[2][15:7] == 9'h1ff);
    params_ok = ({cw_r[4], cw_r[5]} <= `SCD_SPEED_MAX) &&
                (cw_r[6] >= `SCD_RAMP_MIN) && (cw_r[6] <= `SCD_RAMP_MAX) &&
                (cw_r[7] >= `SCD_RAMP_MIN) && (cw_r[7] <= `SCD_RAMP_MAX) &&
                (cw_r[9] <= `SCD_JERK_MAX);
    kind_nxt = SCD_MV_NONE;
    if (rise[`SCD_W0_RUN_ASM]) begin
      // type bit picks blend or dwell
      kind_nxt = w1[`SCD_W1_ASM_TYPE] ? SCD_MV_DWELL : SCD_MV_BLEND;
    end else if (rise[`SCD_W0_JOG_CW] | rise[`SCD_W0_JOG_CCW]) begin
      kind_nxt = w1[`SCD_W1_REG_MOVE] ? SCD_MV_REG : SCD_MV_JOG;
    end else if (rise[`SCD_W0_REL]) begin
      kind_nxt = SCD_MV_REL;
    end else if (rise[`SCD_W0_ABS]) begin
      kind_nxt = SCD_MV_ABS;
    end
    key_match = (keys == 3'b101);
    key_block = (kind_nxt == SCD_MV_REG) || (kind_nxt == SCD_MV_DWELL) ||
                (kind_nxt == SCD_MV_BLEND) ||
                w0[`SCD_W0_RUN_ASM] ||
                ((w0[`SCD_W0_JOG_CW] | w0[`SCD_W0_JOG_CCW]) & w1[`SCD_W1_REG_MOVE]);
  end
  ////////////////////////////////////////////////////////////////////////
  // launch qualifiers; stop and hold take priority over immediate moves, not over a start edge launch
  always_comb begin
    fire_now = evt_vld && is_move && !rise[`SCD_W0_ISTOP] && !rise[`SCD_W0_HOLD] &&
               ((kind_nxt == SCD_MV_ABS || kind_nxt == SCD_MV_REL) ? (pos_ok & params_ok)
                : 1'b1) && !w1[`SCD_W1_INDEXED];
    fire_idx = (state_r == SCD_WAIT_INDEX) && start_rise;
  end
  ////////////////////////////////////////////////////////////////////////
  // state machine: wait for the start indexer input
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      SCD_IDLE: begin
        // indexed move parks here
        if (evt_vld && is_move && w1[`SCD_W1_INDEXED] && !rise[`SCD_W0_ISTOP] &&
            !rise[`SCD_W0_HOLD]) begin
          state_nxt = SCD_WAIT_INDEX;
        end
      end
      SCD_WAIT_INDEX: begin
        // stop cancels, start edge launches
        if (evt_vld && rise[`SCD_W0_ISTOP]) begin
          state_nxt = SCD_IDLE;
        end else if (start_rise) begin
          state_nxt = SCD_IDLE;
        end
      end
      default: begin
        state_nxt = SCD_IDLE;
      end
    endcase
  end
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      state_r <= SCD_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // start input edge; input already synchronous
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      start_prev_r <= 1'b0;
    end else begin
      start_prev_r <= start_in;
    end
  end
  assign start_rise = start_in & ~start_prev_r;
  ////////////////////////////////////////////////////////////////////////
  // move parameters, latched when a move is taken
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      kind_r <= SCD_MV_NONE;
      move_ccw <= 1'b0;
      enc_reg_move <= 1'b0;
      target_pos <= 32'h0000_0000;
      reg_min_dist <= 32'h0000_0000;
      dwell_ms <= 16'h0000;
    end else if (evt_vld && is_move && !rise[`SCD_W0_ISTOP] && !rise[`SCD_W0_HOLD]) begin
      kind_r <= kind_nxt;
      case (kind_nxt)
        SCD_MV_ABS, SCD_MV_REL: begin
          // upper word first
          target_pos <= {cw_r[2], cw_r[3]};
          enc_reg_move <= w1[`SCD_W1_ENC_REG];
          move_ccw <= 1'b0;
        end
        SCD_MV_JOG: begin
          move_ccw <= rise[`SCD_W0_JOG_CCW];
          enc_reg_move <= 1'b0;
        end
        SCD_MV_REG: begin
          // stopping distance and minimum distance
          move_ccw <= rise[`SCD_W0_JOG_CCW];
          target_pos <= {cw_r[2], cw_r[3]};
          reg_min_dist <= {cw_r[8], cw_r[9]};
          enc_reg_move <= 1'b0;
        end
        SCD_MV_BLEND: begin
          move_ccw <= w1[`SCD_W1_REV_BLEND];
          enc_reg_move <= 1'b0;
        end
        SCD_MV_DWELL: begin
          dwell_ms <= cw_r[9];
          move_ccw <= 1'b0;
          enc_reg_move <= 1'b0;
        end
        default: begin
          enc_reg_move <= 1'b0;
        end
      endcase
    end
  end
  assign move_kind = kind_r;
  ////////////////////////////////////////////////////////////////////////
  // speed and ramps, shared by moves other than blend and dwell and by resume; hold and stop skip them
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      speed <= 32'h0000_0000;
      accel <= 16'h0000;
      decel <= 16'h0000;
      jerk <= 16'h0000;
    end else if (evt_vld && !rise[`SCD_W0_ISTOP] && !rise[`SCD_W0_HOLD] && params_ok &&
                 ((is_move && kind_nxt != SCD_MV_BLEND && kind_nxt != SCD_MV_DWELL) ||
                  rise[`SCD_W0_RESUME])) begin
      speed <= {cw_r[4], cw_r[5]};
      accel <= cw_r[6];
      decel <= cw_r[7];
      jerk <= (kind_nxt == SCD_MV_REG) ? jerk : cw_r[9];
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // command pulses, one cycle each
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      move_go <= 1'b0;
      hold_go <= 1'b0;
      resume_go <= 1'b0;
      istop_go <= 1'b0;
      save_go <= 1'b0;
    end else begin
      move_go <= fire_now | fire_idx;
      // stop has no ramp; data words disregarded
      istop_go <= evt_vld & rise[`SCD_W0_ISTOP];
      // hold ramps to start speed downstream
      hold_go <= evt_vld & rise[`SCD_W0_HOLD] & ~rise[`SCD_W0_ISTOP];
      // resume keeps the held target
      resume_go <= evt_vld & rise[`SCD_W0_RESUME] & ~rise[`SCD_W0_ISTOP] &
                   ~rise[`SCD_W0_HOLD] & params_ok;
      save_go <= evt_vld & fall[`SCD_W0_PROG_ASM] & w1[`SCD_W1_SAVE];
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // position validity: lost only when stopped mid-move
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      pos_invalid <= 1'b0;
    end else if (evt_vld && rise[`SCD_W0_ISTOP] && move_busy) begin
      pos_invalid <= 1'b1;
    end else if (evt_vld && rise[`SCD_W0_PRESET]) begin
      pos_invalid <= 1'b0;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // mode levels follow the option word at each update
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      gear_mode <= 1'b0;
      hybrid_mode <= 1'b0;
    end else if (evt_vld) begin
      gear_mode <= w1[`SCD_W1_GEAR];
      hybrid_mode <= w1[`SCD_W1_HYBRID];
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // keyed current, accepted in any state at an update unless a registration or assembled move blocks it
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      motor_current <= `SCD_CUR_RESET;
    end else if (evt_vld && key_match && !key_block) begin
      motor_current <= cur_new;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // error flag: rejected parameters; a new event beats the clear
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      cmd_error <= 1'b0;
    end else if (evt_vld && ((is_move && (kind_nxt == SCD_MV_ABS || kind_nxt == SCD_MV_REL)
                 && !(pos_ok && params_ok)) || (rise[`SCD_W0_RESUME] && !params_ok))) begin
      cmd_error <= 1'b1;
    end else if (evt_vld && rise[`SCD_W0_RST_ERR]) begin
      cmd_error <= 1'b0;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // read mux, data stands one cycle after the strobe
  always_comb begin
    rd_nxt = 16'h0000;
    if (addr < `SCD_REG_COMMIT) begin
      rd_nxt = cw_r[addr[3:0]];
    end else begin
      case (addr)
        `SCD_REG_CURRENT: rd_nxt = motor_current;
        `SCD_REG_STATUS: rd_nxt = {9'h000, cmd_error, pos_invalid, hybrid_mode, gear_mode,
                                   (state_r == SCD_WAIT_INDEX), cur_ok, move_busy};
        `SCD_REG_DWELL: rd_nxt = dwell_ms;
        default: rd_nxt = 16'h0000;
      endcase
    end
  end
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rdata <= 16'h0000;
    end else if (rd_en) begin
      rdata <= rd_nxt;
    end else begin
      rdata <= 16'h0000;
    end
  end
endmodule : scd_decoder
`default_nettype wire

// ===== verilog/scd_map.svh
`ifndef SCD_MAP_SVH
`define SCD_MAP_SVH
////////////////////////////////////////////////////////////////////////
// register indices on the plain port
`define SCD_ADDR_W 5
`define SCD_NWORDS 10
`define SCD_REG_COMMIT 5'h0a
`define SCD_REG_CURRENT 5'h10
`define SCD_REG_STATUS 5'h11
`define SCD_REG_DWELL 5'h12
////////////////////////////////////////////////////////////////////////
// command word 0 bit positions
`define SCD_W0_ABS 0
`define SCD_W0_REL 1
`define SCD_W0_HOLD 2
`define SCD_W0_RESUME 3
`define SCD_W0_ISTOP 4
`define SCD_W0_JOG_CW 7
`define SCD_W0_JOG_CCW 8
`define SCD_W0_PRESET 9
`define SCD_W0_RST_ERR 10
`define SCD_W0_PROG_ASM 11
`define SCD_W0_RUN_ASM 13
////////////////////////////////////////////////////////////////////////
// command word 1 bit positions
`define SCD_W1_KEY0 0
`define SCD_W1_KEY1 1
`define SCD_W1_ENC_REG 2
`define SCD_W1_HYBRID 3
`define SCD_W1_REV_BLEND 4
`define SCD_W1_SAVE 5
`define SCD_W1_GEAR 6
`define SCD_W1_REG_MOVE 7
`define SCD_W1_INDEXED 8
`define SCD_W1_ASM_TYPE 9
////////////////////////////////////////////////////////////////////////
// limits on data words
`define SCD_SPEED_MAX 32'h002d_c6bf
`define SCD_RAMP_MIN 16'h0001
`define SCD_RAMP_MAX 16'h1388
`define SCD_JERK_MAX 16'h1388
`define SCD_CUR_MIN 16'h000a
`define SCD_CUR_MAX_A 16'h003c
`define SCD_CUR_MAX_B 16'h002c
`define SCD_CUR_RESET 16'h000a
`endif

// ===== verilog/scd_pkg.sv
package scd_pkg;
  // decoder state
  typedef enum logic [0:0] {
    SCD_IDLE,
    SCD_WAIT_INDEX
  } scd_state_t;
  // kind of move handed to the profile generator
  typedef enum logic [2:0] {
    SCD_MV_NONE,
    SCD_MV_ABS,
    SCD_MV_REL,
    SCD_MV_JOG,
    SCD_MV_REG,
    SCD_MV_BLEND,
    SCD_MV_DWELL
  } scd_move_t;
endpackage : scd_pkg

// ===== verilog/scd_edge_detect.sv
`timescale 1ns/1ps
`default_nettype none
module scd_edge_detect (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic upd,
  input wire logic [15:0] word,
  output logic [15:0] rise,
  output logic [15:0] fall,
  output logic vld
);
  import scd_pkg::*;
  logic [15:0] prev_r; // word seen at the previous update
  ////////////////////////////////////////////////////////////////////////
  // one detector per bit, compared only across updates
  genvar gi;
  for (gi = 0; gi < 16; gi++) begin : g_bit
    always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
        prev_r[gi] <= 1'b0;
        rise[gi] <= 1'b0;
        fall[gi] <= 1'b0;
      end else if (upd) begin
        prev_r[gi] <= word[gi];
        rise[gi] <= word[gi] & ~prev_r[gi];
        fall[gi] <= ~word[gi] & prev_r[gi];
      end else begin
        rise[gi] <= 1'b0;
        fall[gi] <= 1'b0;
      end
    end
  end
  // strobe marking the cycle the edges are valid
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      vld <= 1'b0;
    end else begin
      vld <= upd;
    end
  end
endmodule : scd_edge_detect
`default_nettype wire

// ===== verilog/scd_current_check.sv
`timescale 1ns/1ps
`default_nettype none
`include "scd_map.svh"
module scd_current_check (
  input wire logic [15:0] req,
  input wire logic model_sel,
  input wire logic [15:0] cfg_current,
  output logic ok,
  output logic [15:0] applied
);
  import scd_pkg::*;
  logic [15:0] max_c; // top of range for the fitted model
  ////////////////////////////////////////////////////////////////////////
  // even tenths within model range, else configured value
  always_comb begin
    max_c = model_sel ? `SCD_CUR_MAX_B : `SCD_CUR_MAX_A;
    ok = ~req[0] && (req >= `SCD_CUR_MIN) && (req <= max_c);
    applied = ok ? req : cfg_current;
  end
endmodule : scd_current_check
`default_nettype wire

// ===== tb/scd_decoder_properties.sv
`timescale 1ns/1ps
`default_nettype none
`include "scd_map.svh"
module scd_decoder_checker
  import scd_pkg::*;
(
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic [`SCD_ADDR_W-1:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [15:0] rdata,
  input wire logic start_in,
  input wire logic model_sel,
  input wire logic [15:0] cfg_current,
  input wire logic move_go,
  input wire scd_pkg::scd_move_t move_kind,
  input wire logic move_ccw,
  input wire logic enc_reg_move,
  input wire logic hold_go,
  input wire logic istop_go,
  input wire logic save_go,
  input wire logic gear_mode,
  input wire logic hybrid_mode,
  input wire logic [15:0] motor_current
);
  import scd_pkg::*;
  logic [15:0] w1_r; // last word one written
  logic [15:0] c1_r; // word one at last commit
  logic [3:0] cm_r; // cycles since commit
  logic cur_ok; // applied current in range
  wire commit = wr_en && addr == `SCD_REG_COMMIT;
  ////////////////////////////////////////////////////////////////////////
  // track word one and commit age
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      w1_r <= 16'h0000;
      c1_r <= 16'h0000;
      cm_r <= 4'hf;
    end else begin
      if (wr_en && addr == 5'h01) begin
        w1_r <= wdata;
      end
      if (commit) begin
        c1_r <= w1_r;
        cm_r <= 4'h0;
      end else if (cm_r != 4'hf) begin
        cm_r <= cm_r + 4'h1;
      end
    end
  end
  // even value inside the model range
  assign cur_ok = !motor_current[0] && motor_current >= `SCD_CUR_MIN &&
    motor_current <= (model_sel ? `SCD_CUR_MAX_B : `SCD_CUR_MAX_A);
  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  a_rdata_idle_zero: assert property (!$past(rd_en) |-> rdata == 16'h0000)
    else $error("read data not zero outside read cycle");
  a_go_one_shot: assert property (move_go |=> !move_go)
    else $error("move launch longer than one cycle");
  a_go_has_cause: assert property (move_go |-> cm_r <= 4'h3 ||
    ($past(start_in) && !$past(start_in, 2)) || ($past(start_in, 2) && !$past(start_in, 3)))
    else $error("move launch without commit or start edge");
  a_hold_after_commit: assert property (hold_go |-> cm_r <= 4'h3 && !move_go)
    else $error("hold pulse without commit or with move");
  a_stop_alone: assert property (istop_go |-> !hold_go && !move_go)
    else $error("stop pulse joined by other command");
  a_mode_follow_word: assert property ($changed(gear_mode) || $changed(hybrid_mode)
    |-> cm_r <= 4'h3 && gear_mode == c1_r[6] && hybrid_mode == c1_r[3])
    else $error("mode level not from committed word one");
  a_save_needs_flag: assert property (save_go |-> cm_r <= 4'h3 && c1_r[5])
    else $error("save pulse without save flag");
  a_current_valid: assert property ($changed(motor_current) |-> cm_r <= 4'h3 &&
    (cur_ok || motor_current == cfg_current))
    else $error("applied current invalid");
  a_asm_kind_dir: assert property (move_go && move_kind inside {SCD_MV_BLEND, SCD_MV_DWELL}
    |-> (move_kind == SCD_MV_DWELL) == c1_r[9] && (c1_r[9] || move_ccw == c1_r[4]))
    else $error("assembled move type or direction wrong");
  a_enc_flag_abs_rel: assert property (move_go && move_kind inside {SCD_MV_ABS, SCD_MV_REL}
    |-> enc_reg_move == c1_r[2])
    else $error("encoder registration flag wrong");
  a_jog_reg_kind: assert property (move_go && move_kind inside {SCD_MV_JOG, SCD_MV_REG}
    |-> (move_kind == SCD_MV_REG) == c1_r[7])
    else $error("jog kind wrong");
endmodule : scd_decoder_checker
`default_nettype wire

// ===== tb/scd_master_model.sv
`timescale 1ns/1ps
`default_nettype none
`include "scd_map.svh"
module scd_master_model (
  input wire logic mclk,
  output var logic [`SCD_ADDR_W-1:0] addr,
  output var logic [15:0] wdata,
  output var logic wr_en,
  output var logic rd_en,
  input wire logic [15:0] rdata
);
  // bus idle at time zero
  initial begin
    addr = '0;
    wdata = 16'h0000;
    wr_en = 1'b0;
    rd_en = 1'b0;
  end
  // one write, strobe left high for a follower
  task automatic put(input logic [`SCD_ADDR_W-1:0] a, input logic [15:0] d);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge mclk);
  endtask : put
  // release strobe, scramble stale data
  task automatic idle();
    wr_en <= 1'b0;
    wdata <= ~wdata;
  endtask : idle
  // whole block then commit, upper halves first
  task automatic send(input logic [15:0] w [0:9]);
    for (int i = 0; i < `SCD_NWORDS; i++) begin
      put(i[`SCD_ADDR_W-1:0], w[i]);
    end
    put(`SCD_REG_COMMIT, 16'h0000);
    idle();
  endtask : send
  // read, data taken at the rising edge that closes the answer cycle
  task automatic rd(input logic [`SCD_ADDR_W-1:0] a, output logic [15:0] d);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge mclk);
    rd_en <= 1'b0;
    @(posedge mclk);
    d = rdata;
  endtask : rd
endmodule : scd_master_model
`default_nettype wire

// ===== tb/stepper_command_decoder_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "scd_map.svh"
module stepper_command_decoder_tb;
  import scd_pkg::*;
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic [`SCD_ADDR_W-1:0] addr;
  logic [15:0] wdata, rdata, accel, decel, jerk, dwell_ms, motor_current;
  logic wr_en, rd_en, move_go, move_ccw, enc_reg_move, hold_go, resume_go, istop_go;
  logic save_go, pos_invalid, gear_mode, hybrid_mode, cmd_error;
  logic start_in = 1'b0;
  logic move_busy = 1'b0;
  logic model_sel = 1'b0;
  logic [15:0] cfg_current = 16'h0018;
  logic [31:0] target_pos, speed, reg_min_dist;
  scd_move_t move_kind, mk;
  logic s_mv, s_hd, s_rs, s_st, s_sv; // pulses seen
  logic [15:0] blk [0:9]; // command block
  logic [15:0] d;
  int n_errors = 0;
  int cmp_count = 0;
  ////////////////////////////////////////////////////////////////////////
  always #20 mclk = ~mclk; // 25 MHz
  scd_decoder u_scd_decoder (.mclk, .reset_n, .addr, .wdata, .wr_en, .rd_en, .rdata,
    .start_in, .move_busy, .model_sel, .cfg_current, .move_go, .move_kind, .move_ccw,
    .enc_reg_move, .target_pos, .speed, .accel, .decel, .jerk, .dwell_ms, .reg_min_dist,
    .hold_go, .resume_go, .istop_go, .save_go, .pos_invalid, .gear_mode, .hybrid_mode,
    .motor_current, .cmd_error);
  scd_master_model u_scd_master_model (.mclk, .addr, .wdata, .wr_en, .rd_en, .rdata);
  // latch pulses and launched kind
  always @(posedge mclk) begin
    if (move_go) begin
      s_mv <= 1'b1;
      mk <= move_kind;
    end
    if (hold_go) s_hd <= 1'b1;
    if (resume_go) s_rs <= 1'b1;
    if (istop_go) s_st <= 1'b1;
    if (save_go) s_sv <= 1'b1;
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    cmp_count++;
    if (got !== ex) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, ex, got);
    end
  endtask : chk
  // send block with words zero and one, let pulses land
  task automatic cmd(input logic [15:0] w0, input logic [15:0] w1);
    {s_mv, s_hd, s_rs, s_st, s_sv} = 5'h00;
    blk[0] = w0;
    blk[1] = w1;
    u_scd_master_model.send(blk);
    repeat (5) @(posedge mclk);
  endtask : cmd
  task automatic t_regs();
    chk("current_rst", 32'h000a, motor_current);
    chk("gear_rst", 32'h0, {gear_mode, hybrid_mode, move_go});
    u_scd_master_model.put(5'h05, 16'h1234);
    u_scd_master_model.idle();
    u_scd_master_model.rd(5'h05, d);
    chk("word5", 32'h1234, d);
    u_scd_master_model.rd(5'h1f, d);
    chk("unmapped", 32'h0, d);
    u_scd_master_model.rd(`SCD_REG_CURRENT, d);
    chk("cur_reg", 32'h000a, d);
    $display("test regs done");
  endtask : t_regs
  task automatic t_moves();
    blk = '{16'h0, 16'h0, 16'hff80, 16'h0000, 16'h002d, 16'hc6bf, 16'h0001, 16'h1388,
      16'h0014, 16'h1388};
    cmd(16'h0001, 16'h0004);
    chk("abs_go", {1'b1, SCD_MV_ABS}, {s_mv, mk});
    chk("abs_tgt", 32'hff80_0000, target_pos);
    chk("speed", 32'h002d_c6bf, speed);
    chk("ramps", 32'h0001_1388, {accel, decel});
    chk("jerk", 32'h1388, jerk);
    chk("enc", 32'h1, enc_reg_move);
    cmd(16'h0001, 16'h0000);
    chk("level_no_go", 32'h0, s_mv);
    cmd(16'h0000, 16'h0100);
    blk[2] = 16'h007f;
    blk[3] = 16'hffff;
    cmd(16'h0002, 16'h0000);
    chk("rel_go", {1'b1, SCD_MV_REL}, {s_mv, mk});
    chk("rel_tgt", 32'h007f_ffff, target_pos);
    cmd(16'h0000, 16'h0000);
    cmd(16'h0001, 16'h0100);
    chk("idx_wait", 32'h0, s_mv);
    start_in <= 1'b1;
    repeat (4) @(posedge mclk);
    chk("idx_go", {1'b1, SCD_MV_ABS}, {s_mv, mk});
    start_in <= 1'b0;
    $display("test moves done");
  endtask : t_moves
  task automatic t_hold_stop();
    blk = '{16'h0, 16'h0, 16'h5a5a, 16'h5a5a, 16'h5a5a, 16'h5a5a, 16'h5a5a, 16'h5a5a,
      16'h5a5a, 16'h5a5a};
    move_busy <= 1'b1;
    cmd(16'h0004, 16'h0000);
    chk("hold", 32'h1, {s_mv, s_hd});
    chk("hold_tgt", 32'h007f_ffff, target_pos);
    cmd(16'h0008, 16'h0000);
    chk("bad_resume", 32'h1, {s_rs, cmd_error});
    chk("bad_speed", 32'h002d_c6bf, speed);
    cmd(16'h0000, 16'h0000);
    blk[4:9] = '{16'h0000, 16'h0100, 16'h0064, 16'h0064, 16'h000a, 16'h0000};
    cmd(16'h0008, 16'h0000);
    chk("resume", 32'h1, s_rs);
    chk("res_tgt", 32'h007f_ffff, target_pos);
    chk("res_speed", 32'h0000_0100, speed);
    cmd(16'h0010, 16'h0000);
    chk("stop", 32'h1, {s_mv, s_st});
    chk("pos_inv", 32'h1, pos_invalid);
    move_busy <= 1'b0;
    cmd(16'h0400, 16'h0000);
    chk("err_clr", 32'h0, cmd_error);
    $display("test hold_stop done");
  endtask : t_hold_stop
  task automatic t_current();
    logic [15:0] val [4] = '{16'h0014, 16'h0015, 16'h002c, 16'h002e};
    logic [15:0] exp [4] = '{16'h0014, 16'h0018, 16'h002c, 16'h0018};
    model_sel <= 1'b1;
    move_busy <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      blk[8] = val[i];
      cmd(16'h0000, 16'h0069);
      chk("cur", exp[i], motor_current);
    end
    chk("modes", 32'h3, {gear_mode, hybrid_mode});
    u_scd_master_model.rd(`SCD_REG_CURRENT, d);
    chk("cur_back", 32'h0018, d);
    blk[8] = 16'h0030;
    cmd(16'h0000, 16'h0000);
    chk("cur_keep", 32'h0018, motor_current);
    chk("modes_off", 32'h0, {gear_mode, hybrid_mode});
    move_busy <= 1'b0;
    $display("test current done");
  endtask : t_current
  task automatic t_asm_jog();
    blk[2] = 16'h0000;
    blk[3] = 16'h0100;
    blk[9] = 16'h01f4;
    cmd(16'h2000, 16'h0010);
    chk("blend", {1'b1, SCD_MV_BLEND, 1'b1}, {s_mv, mk, move_ccw});
    cmd(16'h0000, 16'h0000);
    cmd(16'h2000, 16'h0200);
    chk("dwell", {1'b1, SCD_MV_DWELL}, {s_mv, mk});
    chk("dwell_ms", 32'h01f4, dwell_ms);
    cmd(16'h0080, 16'h0000);
    chk("jog", {1'b1, SCD_MV_JOG}, {s_mv, mk});
    cmd(16'h0000, 16'h0000);
    cmd(16'h0080, 16'h0080);
    chk("reg", {1'b1, SCD_MV_REG}, {s_mv, mk});
    chk("reg_dist", 32'h0030_01f4, reg_min_dist);
    cmd(16'h0800, 16'h0020);
    cmd(16'h0000, 16'h0020);
    chk("save", 32'h1, s_sv);
    $display("test asm_jog done");
  endtask : t_asm_jog
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : summarize
  ////////////////////////////////////////////////////////////////////////
  // hang guard
  initial begin
    #2000000;
    n_errors++;
    summarize();
  end
  // main sequence
  initial begin
    repeat (5) @(posedge mclk);
    reset_n <= 1'b1;
    @(posedge mclk);
    t_regs();
    t_moves();
    t_hold_stop();
    t_current();
    t_asm_jog();
    summarize();
  end
endmodule : stepper_command_decoder_tb
bind scd_decoder scd_decoder_checker u_chk (.mclk, .reset_n, .addr, .wdata, .wr_en, .rd_en,
  .rdata, .start_in, .model_sel, .cfg_current, .move_go, .move_kind, .move_ccw,
  .enc_reg_move, .hold_go, .istop_go, .save_go, .gear_mode, .hybrid_mode, .motor_current);
`default_nettype wire
